/* File: core/cpp_cfg.svh */
`ifndef CPP_CFG_SVH
`define CPP_CFG_SVH
`define CPP_CLK_HZ      100000000
`define CPP_OSC_FAST_HZ 10000000
`define CPP_OSC_SLOW_HZ 1250000
`define CPP_HALF_FAST   (`CPP_CLK_HZ / (2 * `CPP_OSC_FAST_HZ))
`define CPP_HALF_SLOW   (`CPP_CLK_HZ / (2 * `CPP_OSC_SLOW_HZ))
`define CPP_POR_NS      1000
`define CPP_CLR_NS      2000
`define CPP_POR_CYC     ((`CPP_POR_NS * (`CPP_CLK_HZ / 1000000) + 999) / 1000)
`define CPP_CLR_CYC     ((`CPP_CLR_NS * (`CPP_CLK_HZ / 1000000) + 999) / 1000)
`define CPP_MODE_TABLE  24'hfac688
`define CPP_CFG_BYTES   24'h000400
`define CPP_SYNC_W      20
`define CPP_B_INIT      19
`define CPP_B_PRGM      18
`define CPP_B_RST       17
`define CPP_B_CFG_STROBE_CLOCK      16
`define CPP_B_STRAP     12
`define CPP_B_DATA      4
`endif

/* File: core/cpp_pkg.sv */
package cpp_pkg;
    typedef enum logic [2:0] {
        MD_MSER, MD_SSER, MD_MPAR, MD_SPAR, MD_APER, MD_SPER, MD_RSV6, MD_RSV7
    } cpp_mode_t;
    typedef enum logic [2:0] {ST_POR, ST_CLEAR, ST_WAIT, ST_LOAD, ST_DONE} cpp_state_t;
    typedef struct packed {
        logic       select_low_n;
        logic       select_high;
        logic       wr_n;
        logic       rd_n;
    } cpp_host_t;
    typedef struct packed {
        logic [2:0] mode;
        logic       osc_slow;
    } cpp_straps_t;
endpackage : cpp_pkg

/* File: core/cpp_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cpp_cfg.svh"
module cpp_top #(
    parameter logic [23:0] MODE_TABLE = `CPP_MODE_TABLE,
    parameter logic [23:0] CFG_BYTES  = `CPP_CFG_BYTES
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              init_in,
    output logic                   init_out,
    output logic                   init_oe_n,
    input  wire logic              restart_n,
    input  wire logic              reset_pin,
    input  wire logic              mode_strap_bit0,
    input  wire logic              mode_strap_bit1,
    input  wire logic              mode_strap_bit2,
    input  wire logic              osc_speed_strap,
    input  wire cpp_pkg::cpp_host_t host,
    input  wire logic [7:0]        data_in,
    output logic                   status_bit_line,
    output logic                   status_oe_n,
    output logic                   ready_out,
    input  wire logic              cfg_strobe_clock_in,
    output logic                   cfg_strobe_clock,
    output logic                   cfg_strobe_clock_oe_n,
    output logic [17:0]            addr_out,
    output logic                   addr_oe_n,
    output logic                   serial_out,
    output logic                   cfg_active_high_flag,
    output logic                   cfg_active_high_oe_n,
    output logic                   cfg_active_low_flag,
    output logic                   cfg_active_low_oe_n,
    output logic                   cfg_pullup_en,
    input  wire logic              bscan_selected,
    output logic                   bscan_inhibit
);
    // ==================================================================
    // Helpers
    function automatic logic int_clock(input cpp_pkg::cpp_mode_t m);
        return (m == cpp_pkg::MD_MSER) || (m == cpp_pkg::MD_MPAR) || (m == cpp_pkg::MD_APER);
    endfunction

    // ==================================================================
    // State
    localparam logic [15:0] POR_CYC   = 16'(`CPP_POR_CYC);
    localparam logic [15:0] CLR_CYC   = 16'(`CPP_CLR_CYC);
    localparam logic [7:0]  HALF_FAST = 8'(`CPP_HALF_FAST);
    localparam logic [7:0]  HALF_SLOW = 8'(`CPP_HALF_SLOW);

    cpp_pkg::cpp_state_t       st_r, st_nxt;
    cpp_pkg::cpp_mode_t        mode_r, mode_nxt;
    cpp_pkg::cpp_straps_t      straps_r, straps_nxt;
    logic [`CPP_SYNC_W-1:0]    s1_r, s2_r, s3_r, flt_r, fp_r;
    logic [`CPP_SYNC_W-1:0]    s1_nxt, flt_nxt;
    logic [15:0]               cnt_r, cnt_nxt;
    logic [7:0]                div_r, div_nxt;
    logic                      cfg_strobe_clock_r, cfg_strobe_clock_nxt;
    logic [7:0]                shin_r, shin_nxt, dsh_r, dsh_nxt, buf_r, buf_nxt;
    logic [2:0]                bitc_r, bitc_nxt;
    logic [23:0]               bytes_r, bytes_nxt;
    logic [17:0]               addr_r, addr_nxt;
    logic                      busy_r, busy_nxt, dout_r, dout_nxt;
    logic                      init_oe_n_nxt, st_oe_n_nxt, st_bit_nxt, rdy_nxt;
    logic                      cfg_strobe_clock_oe_n_nxt, a_oe_n_nxt, hdc_nxt, hdc_oe_nxt;
    logic                      ldc_nxt, ldc_oe_nxt, pu_nxt, inh_nxt;
    logic                      tick, rise, fall, cfg_on, sel, wr_fall, byte_ok, restart;
    logic [7:0]                byte_v;
    logic [7:0]                half;

    // ==================================================================
    // Next state
    always_comb begin
        s1_nxt = {init_in, restart_n, reset_pin, cfg_strobe_clock_in, mode_strap_bit2,
                  mode_strap_bit1, mode_strap_bit0, osc_speed_strap, data_in,
                  host.select_low_n, host.select_high, host.wr_n, host.rd_n};
        // Change accepted once stages two and three agree
        flt_nxt = (s3_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
        st_nxt = st_r;
        mode_nxt = mode_r;
        straps_nxt = straps_r;
        cnt_nxt = cnt_r;
        div_nxt = div_r;
        cfg_strobe_clock_nxt = cfg_strobe_clock_r;
        shin_nxt = shin_r;
        dsh_nxt = dsh_r;
        buf_nxt = buf_r;
        bitc_nxt = bitc_r;
        bytes_nxt = bytes_r;
        addr_nxt = addr_r;
        busy_nxt = busy_r;
        dout_nxt = dout_r;
        byte_ok = 1'b0;
        byte_v = flt_r[`CPP_B_DATA +: 8];
        cfg_on = (st_r == cpp_pkg::ST_LOAD);
        restart = ~flt_r[`CPP_B_PRGM] | flt_r[`CPP_B_RST];
        sel = ~flt_r[3] & flt_r[2];
        wr_fall = sel & ~flt_r[1] & ~(~fp_r[3] & fp_r[2] & ~fp_r[1]);
        half = straps_r.osc_slow ? HALF_SLOW : HALF_FAST;
        tick = 1'b0;
        if (cfg_on && int_clock(mode_r)) begin
            if (div_r >= half - 8'h01) begin
                div_nxt = 8'h00;
                tick = 1'b1;
                cfg_strobe_clock_nxt = ~cfg_strobe_clock_r;
            end else begin
                div_nxt = div_r + 8'h01;
            end
        end
        if (int_clock(mode_r)) begin
            rise = tick & ~cfg_strobe_clock_r;
            fall = tick & cfg_strobe_clock_r;
        end else begin
            rise = cfg_on & flt_r[`CPP_B_CFG_STROBE_CLOCK] & ~fp_r[`CPP_B_CFG_STROBE_CLOCK];
            fall = cfg_on & ~flt_r[`CPP_B_CFG_STROBE_CLOCK] & fp_r[`CPP_B_CFG_STROBE_CLOCK];
        end
        unique case (st_r)
            cpp_pkg::ST_POR: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r >= POR_CYC - 16'h0001) begin
                    st_nxt = cpp_pkg::ST_CLEAR;
                    cnt_nxt = 16'h0000;
                end
            end
            cpp_pkg::ST_CLEAR: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r >= CLR_CYC - 16'h0001) begin
                    st_nxt = cpp_pkg::ST_WAIT;
                end
            end
            cpp_pkg::ST_WAIT: begin
                // straps latched, mode decoded by table
                if (flt_r[`CPP_B_INIT] && !fp_r[`CPP_B_INIT] && !restart) begin
                    straps_nxt = flt_r[`CPP_B_STRAP +: 4];
                    mode_nxt = cpp_pkg::cpp_mode_t'(MODE_TABLE[3 * flt_r[`CPP_B_STRAP + 1 +: 3] +: 3]);
                    st_nxt = cpp_pkg::ST_LOAD;
                    bytes_nxt = 24'h000000;
                    addr_nxt = 18'h00000;
                    bitc_nxt = 3'h0;
                    busy_nxt = 1'b0;
                    div_nxt = 8'h00;
                    cfg_strobe_clock_nxt = 1'b0;
                end
            end
            cpp_pkg::ST_LOAD: begin
                unique case (mode_r)
                    cpp_pkg::MD_MSER, cpp_pkg::MD_SSER: begin
                        if (rise) begin
                            shin_nxt = {shin_r[6:0], flt_r[`CPP_B_DATA]};
                            bitc_nxt = bitc_r + 3'h1;
                            byte_ok = (bitc_r == 3'h7);
                        end
                    end
                    cpp_pkg::MD_MPAR: begin
                        if (rise) begin
                            byte_ok = 1'b1;
                            addr_nxt = addr_r + 18'h00001;
                        end
                    end
                    cpp_pkg::MD_SPAR: byte_ok = rise & sel & ~flt_r[1];
                    cpp_pkg::MD_APER: begin
                        if (busy_r && rise) begin
                            bitc_nxt = bitc_r + 3'h1;
                            busy_nxt = (bitc_r != 3'h7);
                        end
                        if (wr_fall && !busy_r) begin
                            buf_nxt = byte_v;
                            busy_nxt = 1'b1;
                            bitc_nxt = 3'h0;
                            byte_ok = 1'b1;
                        end
                    end
                    cpp_pkg::MD_SPER: byte_ok = rise & sel;
                    default: ;
                endcase
                if (byte_ok) begin
                    dsh_nxt = byte_v;
                    bytes_nxt = bytes_r + 24'h000001;
                    if (bytes_r >= CFG_BYTES - 24'h000001) begin
                        st_nxt = cpp_pkg::ST_DONE;
                    end
                end
                if (fall) begin
                    if (mode_r == cpp_pkg::MD_MSER || mode_r == cpp_pkg::MD_SSER) begin
                        dout_nxt = shin_r[0];
                    end else begin
                        dout_nxt = dsh_r[7];
                        dsh_nxt = byte_ok ? byte_v : {dsh_r[6:0], 1'b0};
                    end
                end
            end
            cpp_pkg::ST_DONE: ;
        endcase
        if (restart && (st_r == cpp_pkg::ST_LOAD || st_r == cpp_pkg::ST_WAIT)) begin
            st_nxt = cpp_pkg::ST_CLEAR;
            cnt_nxt = 16'h0000;
        end
        init_oe_n_nxt = ~(st_nxt == cpp_pkg::ST_POR || st_nxt == cpp_pkg::ST_CLEAR);
        // status on top data line, write wins
        st_oe_n_nxt = ~(cfg_on && mode_r == cpp_pkg::MD_APER && sel && !flt_r[0] && flt_r[1]);
        st_bit_nxt = ~busy_nxt;
        rdy_nxt = ~busy_nxt;
        cfg_strobe_clock_oe_n_nxt = ~(st_nxt == cpp_pkg::ST_LOAD && int_clock(mode_nxt));
        a_oe_n_nxt = ~(st_nxt == cpp_pkg::ST_LOAD && mode_nxt == cpp_pkg::MD_MPAR);
        hdc_nxt = 1'b1;
        hdc_oe_nxt = (st_nxt == cpp_pkg::ST_DONE);
        ldc_nxt = 1'b0;
        ldc_oe_nxt = (st_nxt == cpp_pkg::ST_DONE);
        pu_nxt = (st_nxt != cpp_pkg::ST_DONE);
        inh_nxt = (st_nxt == cpp_pkg::ST_DONE) & ~bscan_selected;
    end

    // ==================================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= cpp_pkg::ST_POR;
            mode_r <= cpp_pkg::MD_MSER;
            straps_r <= '0;
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            flt_r <= '0;
            fp_r <= '0;
            cnt_r <= 16'h0000;
            div_r <= 8'h00;
            cfg_strobe_clock_r <= 1'b0;
            shin_r <= 8'h00;
            dsh_r <= 8'h00;
            buf_r <= 8'h00;
            bitc_r <= 3'h0;
            bytes_r <= 24'h000000;
            addr_r <= 18'h00000;
            busy_r <= 1'b0;
            dout_r <= 1'b0;
            init_oe_n <= 1'b0;
            status_oe_n <= 1'b1;
            status_bit_line <= 1'b1;
            ready_out <= 1'b1;
            cfg_strobe_clock_oe_n <= 1'b1;
            addr_oe_n <= 1'b1;
            cfg_active_high_flag <= 1'b1;
            cfg_active_high_oe_n <= 1'b0;
            cfg_active_low_flag <= 1'b0;
            cfg_active_low_oe_n <= 1'b0;
            cfg_pullup_en <= 1'b1;
            bscan_inhibit <= 1'b0;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            straps_r <= straps_nxt;
            s1_r <= s1_nxt;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
            fp_r <= flt_r;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            cfg_strobe_clock_r <= cfg_strobe_clock_nxt;
            shin_r <= shin_nxt;
            dsh_r <= dsh_nxt;
            buf_r <= buf_nxt;
            bitc_r <= bitc_nxt;
            bytes_r <= bytes_nxt;
            addr_r <= addr_nxt;
            busy_r <= busy_nxt;
            dout_r <= dout_nxt;
            init_oe_n <= init_oe_n_nxt;
            status_oe_n <= st_oe_n_nxt;
            status_bit_line <= st_bit_nxt;
            ready_out <= rdy_nxt;
            cfg_strobe_clock_oe_n <= cfg_strobe_clock_oe_n_nxt;
            addr_oe_n <= a_oe_n_nxt;
            cfg_active_high_flag <= hdc_nxt;
            cfg_active_high_oe_n <= hdc_oe_nxt;
            cfg_active_low_flag <= ldc_nxt;
            cfg_active_low_oe_n <= ldc_oe_nxt;
            cfg_pullup_en <= pu_nxt;
            bscan_inhibit <= inh_nxt;
        end
    end

    assign init_out = 1'b0;
    assign cfg_strobe_clock = cfg_strobe_clock_r;
    assign addr_out = addr_r;
    assign serial_out = dout_r;
endmodule // cpp_top
`default_nettype wire

/* File: verification/cpp_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module cpp_chk (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               init_in,
    input wire logic               init_out,
    input wire logic               init_oe_n,
    input wire cpp_pkg::cpp_host_t host,
    input wire logic               status_bit_line,
    input wire logic               status_oe_n,
    input wire logic               ready_out,
    input wire logic               cfg_strobe_clock,
    input wire logic               cfg_strobe_clock_oe_n,
    input wire logic [17:0]        addr_out,
    input wire logic               addr_oe_n,
    input wire logic               serial_out,
    input wire logic               cfg_active_high_flag,
    input wire logic               cfg_active_high_oe_n,
    input wire logic               cfg_active_low_flag,
    input wire logic               cfg_active_low_oe_n,
    input wire logic               cfg_pullup_en,
    input wire logic               bscan_selected,
    input wire logic               bscan_inhibit
);
    logic sel;
    assign sel = !host.select_low_n && host.select_high;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ==========================================
    // Pin behaviour
    chk_init_clear: assert property ($rose(nrst) |-> (!init_oe_n && !init_out) [*8])
        else $error("clear/hold not pulled low after reset");
    chk_hold_wait: assert property ((!init_in) [*8] |-> cfg_strobe_clock_oe_n && addr_oe_n)
        else $error("loading while clear/hold is low");
    chk_sel_needed: assert property ((!sel) [*8] |-> status_oe_n)
        else $error("status driven while not selected");
    chk_wr_busy: assert property (
        $fell(host.wr_n) && sel && ready_out && !cfg_strobe_clock_oe_n && addr_oe_n |-> ##[3:8] !ready_out)
        else $error("write did not make the port busy");
    chk_rd_mirror: assert property (!status_oe_n |-> status_bit_line == ready_out)
        else $error("status line differs from ready");
    chk_wr_wins: assert property ((!host.wr_n && !host.rd_n) [*8] |-> status_oe_n)
        else $error("read served during write");
    chk_addr_step: assert property (
        !$stable(addr_out) && !addr_oe_n && !$past(addr_oe_n) |-> addr_out == $past(addr_out) + 18'h1)
        else $error("address did not step by one");
    chk_dout_fall: assert property (!$stable(serial_out) |-> !cfg_strobe_clock)
        else $error("serial out changed with strobe high");
    chk_flags_drive: assert property (
        cfg_pullup_en == !cfg_active_high_oe_n && cfg_active_low_oe_n == cfg_active_high_oe_n
        && (cfg_active_high_oe_n || (cfg_active_high_flag && !cfg_active_low_flag)))
        else $error("configuration flags or pull-ups wrong");
    chk_bscan_off: assert property ($rose(cfg_active_high_oe_n) |-> ##[0:2] bscan_inhibit == !bscan_selected)
        else $error("test functions not handled at done");
    cov_write: cover property ($fell(ready_out));
    cov_done: cover property ($rose(cfg_active_high_oe_n));
    cov_restart: cover property (!addr_oe_n ##1 addr_oe_n && !init_oe_n);
endmodule // cpp_chk
bind cpp_top cpp_chk u_cpp_chk (
    .clk(clk), .nrst(nrst), .init_in(init_in), .init_out(init_out), .init_oe_n(init_oe_n), .host(host),
    .status_bit_line(status_bit_line), .status_oe_n(status_oe_n), .ready_out(ready_out),
    .cfg_strobe_clock(cfg_strobe_clock), .cfg_strobe_clock_oe_n(cfg_strobe_clock_oe_n),
    .addr_out(addr_out), .addr_oe_n(addr_oe_n), .serial_out(serial_out),
    .cfg_active_high_flag(cfg_active_high_flag), .cfg_active_high_oe_n(cfg_active_high_oe_n),
    .cfg_active_low_flag(cfg_active_low_flag), .cfg_active_low_oe_n(cfg_active_low_oe_n),
    .cfg_pullup_en(cfg_pullup_en), .bscan_selected(bscan_selected), .bscan_inhibit(bscan_inhibit));
`default_nettype wire

/* File: verification/cpp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpp_host_model (
    input wire logic           clk,
    input wire logic           init_oe_n,
    input wire logic           status_bit_line,
    input wire logic           status_oe_n,
    output logic               init_in,
    output cpp_pkg::cpp_host_t host,
    output logic [7:0]         data_in
);
    logic hold_r;
    assign init_in = !(hold_r || !init_oe_n);
    // host bus starts idle: select_high low, select_low_n, strobes and data high
    initial begin
        hold_r = 1'b0;
        host = 4'hb;
        data_in = 8'hff;
    end
    task automatic hold(input logic h);
        @(posedge clk);
        hold_r <= h;
    endtask
    task automatic xfer(input logic [7:0] b, input logic s, input logic w, input logic r,
                        output logic st, output logic st_oe);
        @(posedge clk);
        host <= {1'b0, s, 2'b11};
        data_in <= b;
        @(posedge clk);
        host.wr_n <= !w;
        host.rd_n <= !r;
        repeat (8) @(posedge clk);
        st = status_bit_line;
        st_oe = status_oe_n;
        host.wr_n <= 1'b1;
        host.rd_n <= 1'b1;
        @(posedge clk);
        host <= 4'hb;
        data_in <= 8'hff;
    endtask
endmodule // cpp_host_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic               clk, nrst, restart_n, bscan_selected, slow, st, oe, ext_clk;
    logic [2:0]         strap;
    int                 err_count = 0, total_checks = 0, cyc = 0;
    wire logic          init_in, init_out, init_oe_n, status_bit_line, status_oe_n, ready_out;
    wire logic          cfg_strobe_clock, cfg_strobe_clock_oe_n, addr_oe_n, serial_out, bscan_inhibit;
    wire logic          cfg_active_high_flag, cfg_active_high_oe_n, cfg_active_low_flag, cfg_active_low_oe_n;
    wire logic          cfg_pullup_en;
    wire logic [7:0]    data_in;
    wire logic [17:0]   addr_out;
    wire cpp_pkg::cpp_host_t host;
    cpp_top #(.CFG_BYTES(24'h000008)) u_cpp_top (
        .clk(clk), .nrst(nrst), .init_in(init_in), .init_out(init_out), .init_oe_n(init_oe_n),
        .restart_n(restart_n), .reset_pin(1'b0), .mode_strap_bit0(strap[0]), .mode_strap_bit1(strap[1]),
        .mode_strap_bit2(strap[2]), .osc_speed_strap(slow), .host(host), .data_in(data_in),
        .status_bit_line(status_bit_line), .status_oe_n(status_oe_n), .ready_out(ready_out),
        .cfg_strobe_clock_in(ext_clk), .cfg_strobe_clock(cfg_strobe_clock),
        .cfg_strobe_clock_oe_n(cfg_strobe_clock_oe_n), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
        .serial_out(serial_out), .cfg_active_high_flag(cfg_active_high_flag),
        .cfg_active_high_oe_n(cfg_active_high_oe_n), .cfg_active_low_flag(cfg_active_low_flag),
        .cfg_active_low_oe_n(cfg_active_low_oe_n), .cfg_pullup_en(cfg_pullup_en),
        .bscan_selected(bscan_selected), .bscan_inhibit(bscan_inhibit));
    cpp_host_model u_cpp_host_model (
        .clk(clk), .init_oe_n(init_oe_n), .status_bit_line(status_bit_line), .status_oe_n(status_oe_n),
        .init_in(init_in), .host(host), .data_in(data_in));
    // ==========================================
    // Shared tasks
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic start(input logic [2:0] m, input logic s, input logic b);
        u_cpp_host_model.hold(1'b1);
        nrst <= 1'b0;
        strap <= m;
        slow <= s;
        bscan_selected <= b;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (150) @(posedge clk);
        check(init_oe_n, 1'b0);
        repeat (200) @(posedge clk);
        check({cfg_strobe_clock_oe_n, addr_oe_n, init_oe_n, cfg_active_high_oe_n}, 4'he);
        u_cpp_host_model.hold(1'b0);
        repeat (12) @(posedge clk);
    endtask
    task automatic half(input logic [17:0] exp);
        logic [17:0] n;
        n = 18'h0;
        while (cfg_strobe_clock !== 1'b0) @(posedge clk);
        while (cfg_strobe_clock !== 1'b1) @(posedge clk);
        while (cfg_strobe_clock === 1'b1) begin
            @(posedge clk);
            n++;
        end
        check(n, exp);
    endtask
    task automatic wr(input logic [7:0] b);
        while (ready_out !== 1'b1) @(posedge clk);
        u_cpp_host_model.xfer(b, 1'b1, 1'b1, 1'b0, st, oe);
    endtask
    task automatic wait_done;
        while (cfg_active_high_oe_n !== 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task automatic spar_byte(input logic s, input logic w, input logic c);
        fork
            u_cpp_host_model.xfer(8'h81, s, w, 1'b0, st, oe);
            begin
                repeat (5) @(posedge clk);
                ext_clk <= c;
                repeat (3) @(posedge clk);
                ext_clk <= 1'b0;
            end
        join
    endtask
    // ==========================================
    // Clock, timeout, sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            wrap_up;
        end
    end
    initial begin
        nrst = 1'b0;
        restart_n = 1'b1;
        ext_clk = 1'b0;
        bscan_selected = 1'b0;
        slow = 1'b0;
        strap = 3'h0;
        start(3'h4, 1'b0, 1'b0);
        check({cfg_strobe_clock_oe_n, addr_oe_n}, 2'h1);
        u_cpp_host_model.xfer(8'h00, 1'b1, 1'b0, 1'b1, st, oe);
        check({st, oe}, 2'h2);
        wr(8'ha5);
        check(ready_out, 1'b0);
        u_cpp_host_model.xfer(8'h00, 1'b1, 1'b0, 1'b1, st, oe);
        check({st, oe}, 2'h0);
        while (ready_out !== 1'b1) @(posedge clk);
        u_cpp_host_model.xfer(8'h3c, 1'b1, 1'b1, 1'b1, st, oe);
        check({oe, ready_out}, 2'h2);
        while (ready_out !== 1'b1) @(posedge clk);
        u_cpp_host_model.xfer(8'h5a, 1'b0, 1'b1, 1'b0, st, oe);
        check(ready_out, 1'b1);
        for (int i = 0; i < 5; i++) wr(8'h96 ^ 8'(i));
        check(cfg_active_high_oe_n, 1'b0);
        wr(8'h0f);
        wait_done;
        check({cfg_active_high_oe_n, cfg_active_low_oe_n, cfg_pullup_en, bscan_inhibit}, 4'hd);
        start(3'h2, 1'b0, 1'b1);
        strap <= 3'h0;
        repeat (6) @(posedge clk);
        check({addr_oe_n, cfg_strobe_clock_oe_n, addr_out}, 20'h00001);
        half(18'h5);
        restart_n <= 1'b0;
        strap <= 3'h2;
        repeat (3) @(posedge clk);
        restart_n <= 1'b1;
        repeat (10) @(posedge clk);
        check({init_oe_n, addr_oe_n}, 2'h1);
        wait_done;
        check({cfg_pullup_en, bscan_inhibit}, 2'h0);
        start(3'h3, 1'b0, 1'b0);
        check({cfg_strobe_clock_oe_n, addr_oe_n, ready_out}, 3'h7);
        for (int i = 0; i < 7; i++) spar_byte(1'b1, 1'b1, 1'b1);
        spar_byte(1'b1, 1'b0, 1'b1);
        spar_byte(1'b1, 1'b1, 1'b0);
        spar_byte(1'b0, 1'b1, 1'b1);
        check(cfg_active_high_oe_n, 1'b0);
        spar_byte(1'b1, 1'b1, 1'b1);
        wait_done;
        check({cfg_active_high_oe_n, cfg_pullup_en, addr_oe_n}, 3'h5);
        start(3'h0, 1'b1, 1'b0);
        check({addr_oe_n, cfg_strobe_clock_oe_n}, 2'h2);
        half(18'h28);
        check(serial_out, 1'b1);
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
